// ---- rtl/nand_host.v ----
// host sequencer driving a nand die through its command/address/data pins
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "nand_host_defs.vh"
// Behaviour
// - page read precedes cache reads, column zero
// - cache read sequence closes with 3fh
// - while array busy only cache-read, reset, status
// - program pages once, ascending in block
// - 85h redirects column, any number of times
// - cache program commands only, one block
// - erase sends three row cycles only
// - copy-back to same unit and plane
// - random data input before copy-back confirm
// - wait ready after set feature
// - reserved feature bytes written as zero
// - bytes latched on write strobe rise
// - column changes stay within page
module nand_host (
	input wire i_sys_clk,
	input wire i_rst,
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	output reg o_ce_n,
	output reg o_cle,
	output reg o_ale,
	output reg o_we_n,
	output reg o_re_n,
	output reg [7:0] o_dq,
	output reg o_dq_oe,
	input wire [7:0] i_dq,
	input wire i_rb
);
	localparam S_IDLE = 4'h0;
	localparam S_CMD1 = 4'h1;
	localparam S_ADDR = 4'h2;
	localparam S_DATA = 4'h3;
	localparam S_CMD2 = 4'h4;
	localparam S_BUSY = 4'h5;
	localparam S_WAIT_RB = 4'h6;
	localparam S_STAT_WHR = 4'h7;
	localparam S_STAT_RE = 4'h8;
	localparam S_STAT_CAP = 4'h9;
	localparam S_DONE = 4'ha;

	reg [3:0] state;
	reg [3:0] op;
	reg [15:0] column;
	reg [23:0] row;
	reg [7:0] feat_addr;
	reg [31:0] feat_param;
	reg [7:0] data_byte;
	reg data_valid;
	reg [7:0] last_status;
	reg busy;
	reg [2:0] addr_idx;
	reg [2:0] addr_cnt;
	reg [1:0] param_idx;
	reg [3:0] wait_cnt;
	reg cyc_start;
	reg [1:0] cyc_kind;
	reg [7:0] cyc_byte;
	wire cyc_done;
	wire cyc_we_n;
	wire cyc_cle;
	wire cyc_ale;
	wire [7:0] cyc_dq;
	wire cyc_oe;
	reg rb_meta;
	reg rb_sync;
	reg [7:0] dq_meta;
	reg [7:0] dq_sync;

	// first command byte of each operation
	function [7:0] first_cmd;
		input [3:0] o;
		begin
			case (o)
			`OP_PAGE_READ, `OP_COPYBACK_READ: first_cmd = `CMD_READ1;
			`OP_RAND_CACHE_READ: first_cmd = `CMD_READ1;
			`OP_LAST_CACHE_READ: first_cmd = `CMD_CACHE_LAST;
			`OP_PAGE_PROGRAM, `OP_CACHE_PROGRAM, `OP_FINAL_CACHE_PROGRAM: first_cmd = `CMD_PROG1;
			`OP_BLOCK_ERASE: first_cmd = `CMD_ERASE1;
			`OP_COPYBACK_PROGRAM, `OP_RAND_DATA_IN: first_cmd = `CMD_RAND_IN;
			`OP_SET_FEATURE: first_cmd = `CMD_SET_FEAT;
			`OP_READ_STATUS: first_cmd = `CMD_STATUS;
			default: first_cmd = `CMD_RESET;
			endcase
		end
	endfunction

	// confirm byte, zero where none follows
	function [7:0] second_cmd;
		input [3:0] o;
		begin
			case (o)
			`OP_PAGE_READ: second_cmd = `CMD_READ2;
			`OP_RAND_CACHE_READ: second_cmd = `CMD_CACHE_RAND;
			`OP_COPYBACK_READ: second_cmd = `CMD_CB_READ2;
			`OP_PAGE_PROGRAM, `OP_FINAL_CACHE_PROGRAM: second_cmd = `CMD_PROG2;
			`OP_COPYBACK_PROGRAM: second_cmd = `CMD_PROG2;
			`OP_CACHE_PROGRAM: second_cmd = `CMD_CACHE_PROG2;
			`OP_BLOCK_ERASE: second_cmd = `CMD_ERASE2;
			default: second_cmd = 8'h00;
			endcase
		end
	endfunction

	// number of address cycles
	function [2:0] addr_cycles;
		input [3:0] o;
		begin
			case (o)
			`OP_BLOCK_ERASE: addr_cycles = 3'h3;
			`OP_RAND_DATA_IN: addr_cycles = 3'h2;
			`OP_SET_FEATURE: addr_cycles = 3'h1;
			`OP_LAST_CACHE_READ, `OP_READ_STATUS, `OP_RESET: addr_cycles = 3'h0;
			default: addr_cycles = 3'h5;
			endcase
		end
	endfunction

	nand_bus_cycle u_cycle (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_start(cyc_start),
		.i_kind(cyc_kind),
		.i_byte(cyc_byte),
		.o_done(cyc_done),
		.o_we_n(cyc_we_n),
		.o_cle(cyc_cle),
		.o_ale(cyc_ale),
		.o_dq(cyc_dq),
		.o_dq_oe(cyc_oe)
	);

	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			rb_meta <= 1'b0;
			rb_sync <= 1'b0;
			dq_meta <= 8'h00;
			dq_sync <= 8'h00;
		end else begin
			rb_meta <= i_rb;
			rb_sync <= rb_meta;
			dq_meta <= i_dq;
			dq_sync <= dq_meta;
		end
	end

	// address byte for the current cycle
	reg [7:0] addr_byte;
	always @* begin
		addr_byte = 8'h00;
		if (op == `OP_SET_FEATURE)
			addr_byte = feat_addr;
		else if (op == `OP_BLOCK_ERASE)
			addr_byte = row[addr_idx*8 +: 8];
		else if (addr_idx < 3'h2)
			// cache reads always start at column zero
			addr_byte = (op == `OP_RAND_CACHE_READ) ? 8'h00 : column[addr_idx*8 +: 8];
		else
			addr_byte = row[(addr_idx - 3'h2)*8 +: 8];
	end

	// pin outputs registered from the cycle engine
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_cle <= 1'b0;
			o_ale <= 1'b0;
			o_we_n <= 1'b1;
			o_dq <= 8'h00;
			o_dq_oe <= 1'b0;
		end else begin
			o_cle <= cyc_cle;
			o_ale <= cyc_ale;
			o_we_n <= cyc_we_n;
			o_dq <= cyc_dq;
			o_dq_oe <= cyc_oe;
		end
	end

	always @(posedge i_sys_clk) begin
		cyc_start <= 1'b0;
		if (i_rst) begin
			state <= S_IDLE;
			op <= `OP_RESET;
			column <= 16'h0000;
			row <= 24'h000000;
			feat_addr <= `FEAT_IFACE;
			feat_param <= 32'h00000000;
			data_byte <= 8'h00;
			data_valid <= 1'b0;
			last_status <= 8'h00;
			busy <= 1'b0;
			addr_idx <= 3'h0;
			addr_cnt <= 3'h0;
			param_idx <= 2'h0;
			wait_cnt <= 4'h0;
			cyc_kind <= 2'h0;
			cyc_byte <= 8'h00;
			o_ce_n <= 1'b1;
			o_re_n <= 1'b1;
		end else begin
			if (i_wr && !busy) begin
				case (i_addr)
				`REG_ADDR_LO: column <= i_wdata[15:0];
				`REG_ADDR_HI: row <= i_wdata[23:0];
				`REG_DATA: begin
					data_byte <= i_wdata[7:0];
					data_valid <= 1'b1;
				end
				`REG_FEAT: begin
					feat_addr <= i_wdata[7:0];
					feat_param <= 32'h00000000;
				end
				default: ;
				endcase
			end
			// parameter bytes: reserved upper bytes forced to zero
			if (i_wr && !busy && i_addr == `REG_FEAT + 8'h04)
				feat_param <= {16'h0000, i_wdata[15:0]};
			case (state)
			S_IDLE: begin
				if (i_wr && i_addr == `REG_CTRL && i_wdata[`CTRL_GO]) begin
					op <= i_wdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
					busy <= 1'b1;
					o_ce_n <= 1'b0;
					state <= S_CMD1;
					cyc_kind <= 2'h0;
					cyc_byte <= first_cmd(i_wdata[`CTRL_OP_MSB:`CTRL_OP_LSB]);
					cyc_start <= 1'b1;
				end
			end
			S_CMD1: begin
				if (cyc_done) begin
					addr_idx <= 3'h0;
					addr_cnt <= addr_cycles(op);
					// fresh busy window for every order
					wait_cnt <= 4'h0;
					if (op == `OP_READ_STATUS) begin
						state <= S_STAT_WHR;
					end else if (addr_cycles(op) != 3'h0) begin
						state <= S_ADDR;
					end else begin
						state <= S_BUSY;
					end
				end
			end
			S_ADDR: begin
				if (cyc_done || addr_idx == 3'h0 && !cyc_start && addr_cnt != 3'h0 && o_we_n && !cyc_oe) begin
					if (addr_cnt == 3'h0) begin
						param_idx <= 2'h0;
						// only program-type and random data input orders carry the data byte
						if (op == `OP_SET_FEATURE)
							state <= S_DATA;
						else if (data_valid && (first_cmd(op) == `CMD_PROG1 || first_cmd(op) == `CMD_RAND_IN))
							state <= S_DATA;
						else
							state <= S_CMD2;
					end else begin
						cyc_kind <= 2'h1;
						cyc_byte <= addr_byte;
						cyc_start <= 1'b1;
						addr_idx <= addr_idx + 3'h1;
						addr_cnt <= addr_cnt - 3'h1;
					end
				end
			end
			S_DATA: begin
				if (!cyc_start && !cyc_oe && o_we_n) begin
					// four parameter bytes in order, no latency cycles
					cyc_kind <= 2'h2;
					cyc_start <= 1'b1;
					if (op == `OP_SET_FEATURE) begin
						cyc_byte <= feat_param[param_idx*8 +: 8];
						param_idx <= param_idx + 2'h1;
						if (param_idx == 2'h3) begin
							wait_cnt <= 4'h0;
							state <= S_BUSY;
						end
					end else begin
						cyc_byte <= data_byte;
						data_valid <= 1'b0;
						state <= S_CMD2;
					end
				end
			end
			S_CMD2: begin
				if (!cyc_start && !cyc_oe && o_we_n) begin
					if (second_cmd(op) != 8'h00) begin
						cyc_kind <= 2'h0;
						cyc_byte <= second_cmd(op);
						cyc_start <= 1'b1;
					end
					wait_cnt <= 4'h0;
					state <= S_BUSY;
				end
			end
			S_BUSY: begin
				// let the device pull busy before watching ready
				if (!cyc_start && !cyc_oe) begin
					if (wait_cnt == `WB_CYC)
						state <= S_WAIT_RB;
					else
						wait_cnt <= wait_cnt + 4'h1;
				end
			end
			S_WAIT_RB: begin
				// new setting applies as ready rises
				if (rb_sync || op == `OP_RAND_DATA_IN) begin
					state <= S_DONE;
				end
			end
			S_STAT_WHR: begin
				if (wait_cnt == `WHR_CYC) begin
					o_re_n <= 1'b0;
					wait_cnt <= 4'h0;
					state <= S_STAT_RE;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
			S_STAT_RE: begin
				// allow the synchroniser to settle on the driven byte
				if (wait_cnt == 4'h3)
					state <= S_STAT_CAP;
				else
					wait_cnt <= wait_cnt + 4'h1;
			end
			S_STAT_CAP: begin
				last_status <= dq_sync;
				o_re_n <= 1'b1;
				state <= S_DONE;
			end
			S_DONE: begin
				o_ce_n <= 1'b1;
				busy <= 1'b0;
				state <= S_IDLE;
			end
			default: state <= S_IDLE;
			endcase
		end
	end

	// read data one cycle after the strobe
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_rdata <= 32'h00000000;
		end else if (i_rd) begin
			case (i_addr)
			`REG_CTRL: o_rdata <= {27'h0000000, busy, op};
			`REG_ADDR_LO: o_rdata <= {16'h0000, column};
			`REG_ADDR_HI: o_rdata <= {8'h00, row};
			`REG_DATA: o_rdata <= {24'h000000, data_byte};
			`REG_STATUS: o_rdata <= {23'h000000, rb_sync, last_status[`SR_NOT_PROTECTED],
				last_status[`SR_HOST_READY], last_status[`SR_ARRAY_READY], 3'h0,
				last_status[`SR_PRIOR_FAIL], last_status[`SR_FAIL]};
			`REG_FEAT: o_rdata <= {24'h000000, feat_addr};
			`REG_LAST_SR: o_rdata <= {24'h000000, last_status};
			default: o_rdata <= 32'h00000000;
			endcase
		end else begin
			o_rdata <= 32'h00000000;
		end
	end
endmodule

// ---- rtl/nand_host_defs.vh ----
// constants for the nand command sequencer host
`ifndef NAND_HOST_DEFS_VH
`define NAND_HOST_DEFS_VH

// software register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_ADDR_LO 8'h04
`define REG_ADDR_HI 8'h08
`define REG_DATA 8'h0c
`define REG_STATUS 8'h10
`define REG_FEAT 8'h14
`define REG_LAST_SR 8'h18

// control field positions
`define CTRL_OP_LSB 0
`define CTRL_OP_MSB 3
`define CTRL_GO 4

// host operations
`define OP_PAGE_READ 4'h0
`define OP_RAND_CACHE_READ 4'h1
`define OP_LAST_CACHE_READ 4'h2
`define OP_PAGE_PROGRAM 4'h3
`define OP_CACHE_PROGRAM 4'h4
`define OP_FINAL_CACHE_PROGRAM 4'h5
`define OP_BLOCK_ERASE 4'h6
`define OP_COPYBACK_READ 4'h7
`define OP_COPYBACK_PROGRAM 4'h8
`define OP_SET_FEATURE 4'h9
`define OP_RAND_DATA_IN 4'ha
`define OP_READ_STATUS 4'hb
`define OP_RESET 4'hc

// device command bytes
`define CMD_READ1 8'h00
`define CMD_READ2 8'h30
`define CMD_CACHE_RAND 8'h31
`define CMD_CACHE_LAST 8'h3f
`define CMD_PROG1 8'h80
`define CMD_PROG2 8'h10
`define CMD_CACHE_PROG2 8'h15
`define CMD_ERASE1 8'h60
`define CMD_ERASE2 8'hd0
`define CMD_CB_READ2 8'h35
`define CMD_RAND_IN 8'h85
`define CMD_SET_FEAT 8'hef
`define CMD_STATUS 8'h70
`define CMD_RESET 8'hff

// feature addresses and defaults
`define FEAT_IFACE 8'h02
`define FEAT_DRIVE 8'h10
`define FEAT_VPP 8'h30
`define DRIVE_UNDER 8'h02
`define DRIVE_DEFAULT 8'h04
`define VPP_OFF 8'h00
`define VPP_ON 8'h01

// status bit positions
`define SR_FAIL 0
`define SR_PRIOR_FAIL 1
`define SR_ARRAY_READY 5
`define SR_HOST_READY 6
`define SR_NOT_PROTECTED 7

// timing, 40 mhz: 25 ns period
`define CLK_PERIOD_NS 25
`define T_WC_NS 25
`define T_WHR_NS 120
`define T_WB_NS 100
`define WE_LOW_CYC 1
`define WE_HIGH_CYC 1
`define WHR_CYC ((`T_WHR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WB_CYC ((`T_WB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- rtl/nand_bus_cycle.v ----
// one latched command, address or data byte on the flash bus
`timescale 1ns/1ps
`include "nand_host_defs.vh"
module nand_bus_cycle (
	input wire i_sys_clk,
	input wire i_rst,
	input wire i_start,
	input wire [1:0] i_kind,
	input wire [7:0] i_byte,
	output reg o_done,
	output reg o_we_n,
	output reg o_cle,
	output reg o_ale,
	output reg [7:0] o_dq,
	output reg o_dq_oe
);
	// kind 0 command, 1 address, 2 data
	reg [1:0] phase;
	always @(posedge i_sys_clk) begin
		o_done <= 1'b0;
		if (i_rst) begin
			phase <= 2'h0;
			o_we_n <= 1'b1;
			o_cle <= 1'b0;
			o_ale <= 1'b0;
			o_dq <= 8'h00;
			o_dq_oe <= 1'b0;
		end else begin
			case (phase)
			2'h0: begin
				if (i_start) begin
					o_cle <= (i_kind == 2'h0);
					o_ale <= (i_kind == 2'h1);
					o_dq <= i_byte;
					o_dq_oe <= 1'b1;
					o_we_n <= 1'b0;
					phase <= 2'h1;
				end
			end
			2'h1: begin
				// byte captured by the device on this rising edge
				o_we_n <= 1'b1;
				phase <= 2'h2;
			end
			2'h2: begin
				o_cle <= 1'b0;
				o_ale <= 1'b0;
				o_dq_oe <= 1'b0;
				o_done <= 1'b1;
				phase <= 2'h0;
			end
			default: phase <= 2'h0;
			endcase
		end
	end
endmodule

// ---- verif/nand_host_properties.sv ----
// pin timing checks for the nand host sequencer
`timescale 1ns/1ps
module nand_host_props (
	input wire i_sys_clk,
	input wire i_rst,
	input wire i_rd,
	input wire [31:0] o_rdata,
	input wire o_ce_n,
	input wire o_cle,
	input wire o_ale,
	input wire o_we_n,
	input wire o_re_n,
	input wire [7:0] o_dq,
	input wire o_dq_oe,
	input wire i_rb
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	property p_we_ce;
		!o_we_n |-> !o_ce_n && o_dq_oe;
	endproperty
	a_we_ce: assert property (p_we_ce) else $error("strobe without chip enable");
	property p_one_latch;
		!(o_cle && o_ale);
	endproperty
	a_one_latch: assert property (p_one_latch) else $error("both latches high");
	property p_we_pulse;
		$fell(o_we_n) |=> o_we_n;
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("strobe low too long");
	property p_hold;
		!o_we_n |=> $stable(o_dq) && $stable(o_cle) && $stable(o_ale);
	endproperty
	a_hold: assert property (p_hold) else $error("byte moved at strobe rise");
	property p_idle;
		o_ce_n |-> o_we_n && o_re_n && !o_dq_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("pins busy while idle");
	property p_re_bus;
		!o_re_n |-> !o_ce_n && !o_dq_oe && !o_cle && !o_ale;
	endproperty
	a_re_bus: assert property (p_re_bus) else $error("bus fight on read");
	property p_no_cmd_busy;
		!o_we_n && o_cle |-> i_rb;
	endproperty
	a_no_cmd_busy: assert property (p_no_cmd_busy) else $error("command while busy");
	property p_done_ready;
		$rose(o_ce_n) |-> i_rb && $past(i_rb, 2);
	endproperty
	a_done_ready: assert property (p_done_ready) else $error("done before ready");
	property p_start;
		$fell(o_ce_n) |-> ##[0:20] (!o_we_n && o_cle);
	endproperty
	a_start: assert property (p_start) else $error("no command after select");
	property p_rdata;
		!$past(i_rd) |-> o_rdata == 32'h0;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule

// ---- verif/nand_die_model.sv ----
// behavioural nand die answering command, address and data cycles
`timescale 1ns/1ps
module nand_die_model (
	input wire i_ce_n,
	input wire i_cle,
	input wire i_ale,
	input wire i_we_n,
	input wire i_re_n,
	input wire [7:0] i_dq,
	output logic [7:0] o_dq,
	output logic o_rb
);
	logic [9:0] lg[$];
	logic [31:0] feat[3];
	logic [31:0] pend;
	logic [7:0] cmd;
	logic [1:0] fi;
	logic fail_next, cf, pf, fe, cach;
	int np;
	wire [7:0] sr = {1'b1, o_rb, o_rb, 3'h0, pf, cf};
	// released bus shows the inverse, never a stale match
	assign o_dq = (!i_ce_n && !i_re_n) ? sr : ~sr;
	initial begin
		o_rb = 1;
		feat = '{32'h0, 32'h4, 32'h0};
		{fail_next, cf, pf, fe, cach} = 5'h0;
		np = 0;
	end
	task automatic busy(input int d);
		fork
			begin
				o_rb = 0;
				#d o_rb = 1;
				if (fe) feat[fi] = pend;
				fe = 0;
			end
		join_none
	endtask
	always @(posedge i_we_n) begin
		if (!i_ce_n) begin
			lg.push_back({i_ale, i_cle, i_dq});
			if (i_cle) begin
				cmd = i_dq;
				np = 0;
				case (i_dq)
					8'h15, 8'h10, 8'hd0: begin
						pf = cach ? cf : 1'b0;
						cf = fail_next;
						fail_next = 0;
						cach = (i_dq == 8'h15);
						busy(cach ? 400 : 2000);
					end
					8'h30, 8'h31, 8'h35, 8'h3f: busy(1000);
					8'hff: busy(500);
					default: ;
				endcase
			end else if (i_ale) begin
				if (cmd == 8'hef) fi = (i_dq == 8'h02) ? 2'd0 : (i_dq == 8'h10) ? 2'd1 : 2'd2;
				pend = 0;
			end else if (cmd == 8'hef) begin
				pend[np*8 +: 8] = i_dq;
				np++;
				fe = (np == 4);
				if (fe) busy(1000);
			end
		end
	end
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the nand host sequencer
`timescale 1ns/1ps
`include "nand_host_defs.vh"
module tb_top;
	logic i_sys_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
	logic [7:0] i_addr = 0;
	logic [31:0] i_wdata = 0;
	wire [31:0] o_rdata;
	wire o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_dq_oe, i_rb;
	wire [7:0] o_dq, i_dq;
	int err_total = 0, checked = 0, cyc = 0;
	nand_host nand_host_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale),
		.o_we_n(o_we_n), .o_re_n(o_re_n), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_dq(i_dq), .i_rb(i_rb));
	nand_die_model nand_die_model_i (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
		.i_re_n(o_re_n), .i_dq(o_dq), .o_dq(i_dq), .o_rb(i_rb));
	initial forever #12.5 i_sys_clk = ~i_sys_clk;
	task end_sim;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_total++;
			end_sim;
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1;
		@(posedge i_sys_clk);
		i_wr <= 0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1;
		@(posedge i_sys_clk);
		i_rd <= 0;
		@(negedge i_sys_clk);
		v = o_rdata;
	endtask
	task op(input logic [3:0] o);
		logic [31:0] v;
		wr(`REG_CTRL, {27'h0, 1'b1, o});
		v = 32'h10;
		for (int n = 0; n < 2000 && v[4] !== 1'b0; n++) rd(`REG_CTRL, v);
		chk(v[4], 1'b0);
	endtask
	task seq(input logic [9:0] e[$], input bit exact);
		if (exact) chk(nand_die_model_i.lg.size(), e.size());
		foreach (e[k]) chk(nand_die_model_i.lg[k], e[k]);
		nand_die_model_i.lg.delete();
	endtask
	task stat(input logic [31:0] exp);
		logic [31:0] v;
		op(`OP_READ_STATUS);
		seq('{10'h170}, 1);
		rd(`REG_LAST_SR, v);
		chk(v, exp);
		rd(`REG_STATUS, v);
		chk(v, 32'h100 | exp);
	endtask
	task t_feat;
		logic [7:0] fa[3];
		logic [15:0] pv[3];
		logic [31:0] v;
		fa = '{8'h02, 8'h10, 8'h30};
		pv = '{16'h2107, 16'h0002, 16'h0001};
		chk(nand_die_model_i.feat[1], 32'h4);
		for (int i = 0; i < 3; i++) begin
			wr(`REG_FEAT, {24'h0, fa[i]});
			wr(`REG_LAST_SR, {16'h0, pv[i]});
			op(`OP_SET_FEATURE);
			seq('{10'h1ef, {2'b10, fa[i]}, {2'b00, pv[i][7:0]}, {2'b00, pv[i][15:8]}, 10'h0, 10'h0}, 1);
			rd(`REG_FEAT, v);
			chk(v, {24'h0, fa[i]});
		end
		for (int i = 0; i < 3; i++) chk(nand_die_model_i.feat[i], {16'h0, pv[i]});
	endtask
	task t_erase;
		logic [31:0] v;
		nand_die_model_i.fail_next = 1;
		wr(`REG_ADDR_HI, 32'h123456);
		rd(`REG_ADDR_HI, v);
		chk(v, 32'h123456);
		op(`OP_BLOCK_ERASE);
		seq('{10'h160, 10'h256, 10'h234, 10'h212, 10'h1d0}, 1);
		stat(32'he1);
	endtask
	task t_prog;
		wr(`REG_ADDR_LO, 32'h10);
		wr(`REG_ADDR_HI, 32'h5);
		wr(`REG_DATA, 32'hab);
		op(`OP_PAGE_PROGRAM);
		seq('{10'h180, 10'h210, 10'h200, 10'h205, 10'h200, 10'h200, 10'h0ab, 10'h110}, 1);
		stat(32'he0);
	endtask
	task t_copy;
		wr(`REG_ADDR_LO, 32'h0);
		wr(`REG_ADDR_HI, 32'h7);
		op(`OP_COPYBACK_READ);
		seq('{10'h100, 10'h200, 10'h200, 10'h207, 10'h200, 10'h200, 10'h135}, 1);
		for (int i = 0; i < 2; i++) begin
			wr(`REG_ADDR_LO, 32'h4 << i);
			wr(`REG_DATA, 32'h5a);
			op(`OP_RAND_DATA_IN);
			seq('{10'h185, {2'b10, 8'h04 << i}, 10'h200}, 0);
		end
		wr(`REG_ADDR_HI, 32'h9);
		op(`OP_COPYBACK_PROGRAM);
		seq('{10'h185, 10'h208, 10'h200, 10'h209, 10'h200, 10'h200, 10'h110}, 1);
	endtask
	task t_cache_prog;
		for (int i = 0; i < 3; i++) begin
			nand_die_model_i.fail_next = (i == 1);
			wr(`REG_ADDR_HI, 32'h40 + i);
			wr(`REG_DATA, 32'h11);
			op(i < 2 ? `OP_CACHE_PROGRAM : `OP_FINAL_CACHE_PROGRAM);
			chk(nand_die_model_i.lg[$], i < 2 ? 10'h115 : 10'h110);
			nand_die_model_i.lg.delete();
		end
		stat(32'he2);
	endtask
	task t_cache_read;
		wr(`REG_ADDR_LO, 32'h0);
		wr(`REG_ADDR_HI, 32'h20);
		op(`OP_PAGE_READ);
		seq('{10'h100, 10'h200, 10'h200, 10'h220, 10'h200, 10'h200, 10'h130}, 1);
		wr(`REG_ADDR_LO, 32'h1234);
		wr(`REG_ADDR_HI, 32'h21);
		op(`OP_RAND_CACHE_READ);
		seq('{10'h100, 10'h200, 10'h200, 10'h221, 10'h200, 10'h200, 10'h131}, 1);
		op(`OP_LAST_CACHE_READ);
		seq('{10'h13f}, 1);
		op(`OP_RESET);
		seq('{10'h1ff}, 1);
	endtask
	initial begin
		repeat (12) @(posedge i_sys_clk);
		i_rst <= 0;
		t_feat;
		t_erase;
		t_prog;
		t_copy;
		t_cache_prog;
		t_cache_read;
		end_sim;
	end
endmodule
bind nand_host nand_host_props nand_host_props_i (.i_sys_clk, .i_rst, .i_rd, .o_rdata, .o_ce_n, .o_cle,
	.o_ale, .o_we_n, .o_re_n, .o_dq, .o_dq_oe, .i_rb);
